// file: eqes_pkg.sv
// Constants and types shared by the error queue and event status logic
package eqes_pkg;
  localparam int QDEPTH = 32;
  localparam int QAW    = 5;
  localparam int CODE_W = 16;
  localparam logic [5:0] QFULL_CNT = 6'h20;
  localparam logic [5:0] QLAST_CNT = 6'h1f;
  localparam logic [7:0] RX_MAX    = 8'hfa;

  // Error codes
  localparam logic [15:0] ERR_NONE         = 16'h0000;
  localparam logic [15:0] ERR_BAD_TEXT     = 16'h0067;
  localparam logic [15:0] ERR_WRONG_COMP   = 16'h006d;
  localparam logic [15:0] ERR_UNKNOWN_COMP = 16'h006e;
  localparam logic [15:0] ERR_WRONG_PARAM  = 16'h006f;
  localparam logic [15:0] ERR_PARSER_OVF   = 16'h00be;
  localparam logic [15:0] ERR_RANGE        = 16'h00c8;
  localparam logic [15:0] ERR_HW           = 16'h012c;
  localparam logic [15:0] ERR_SW           = 16'h012d;
  localparam logic [15:0] ERR_NOT_ENABLED  = 16'h012e;
  localparam logic [15:0] ERR_KEY_EMUL     = 16'h012f;
  localparam logic [15:0] ERR_TOO_MANY     = 16'h0190;
  localparam logic [15:0] ERR_QRY_INTR     = 16'h019a;
  localparam logic [15:0] ERR_QRY_UNTERM   = 16'h01a4;
  localparam logic [15:0] ERR_RX_OVF       = 16'h01f4;
  localparam logic [15:0] ERR_INTERLOCK    = 16'h03e9;
  localparam logic [15:0] ERR_OPEN_CIRC    = 16'h03ea;
  localparam logic [15:0] ERR_OVER_TEMP    = 16'h03eb;
  localparam logic [15:0] ERR_LASER_POL    = 16'h03ed;
  localparam logic [15:0] ERR_MON_POL      = 16'h03ee;
  localparam logic [15:0] ERR_CUR_IN_CP    = 16'h03ef;
  localparam logic [15:0] ERR_MON_IN_CC    = 16'h03f0;
  localparam logic [15:0] ERR_TEMP_WIN     = 16'h03f2;
  localparam logic [15:0] ERR_BIAS_SW      = 16'h03f4;
  localparam logic [15:0] ERR_MON_POL_SET  = 16'h03f5;
  localparam logic [15:0] ERR_CALIBRATE    = 16'h03f6;
  localparam logic [15:0] ERR_MODE         = 16'h03f8;
  localparam logic [15:0] ERR_RANGE_LASER  = 16'h03f9;
  localparam logic [15:0] ERR_RANGE_BIAS   = 16'h03fa;

  // Event flag bit positions and reset values
  localparam int EV_OPC = 0;
  localparam int EV_QYE = 2;
  localparam int EV_DDE = 3;
  localparam int EV_EXE = 4;
  localparam int EV_CME = 5;
  localparam int EV_PON = 7;
  localparam logic [7:0] FLAGS_RST = 8'h80;
  localparam logic [7:0] MASK_RST  = 8'h00;

  typedef enum logic [3:0] {
    REQ_LASER_ON,
    REQ_LASER_POL,
    REQ_MON_POL,
    REQ_MON_POL_SETUP,
    REQ_LASER_CURRENT,
    REQ_MONITOR_SETPOINT,
    REQ_BIAS_SWITCH,
    REQ_CALIBRATE,
    REQ_MODE,
    REQ_MON_RANGE
  } eqes_req_e;
endpackage

// file: eqes_errq.sv
// Thirty-two entry first-in first-out store for error codes
`timescale 1ns/1ps
module eqes_errq (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        push,
  input  wire logic [eqes_pkg::CODE_W-1:0] push_data,
  input  wire logic                        pop,
  output logic      [eqes_pkg::CODE_W-1:0] head,
  output logic      [5:0]                  count
);
  import eqes_pkg::*;

  logic [CODE_W-1:0] mem [QDEPTH];
  logic [QAW-1:0]    wr_ptr_r;
  logic [QAW-1:0]    rd_ptr_r;
  logic [5:0]        count_r;
  logic              do_push;
  logic              do_pop;

  assign do_push = push && (count_r != QFULL_CNT);
  assign do_pop  = pop && (count_r != 6'h00);
  assign head    = mem[rd_ptr_r];
  assign count   = count_r;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 5'h01;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 5'h01;
      end
      count_r <= count_r + {5'h00, do_push} - {5'h00, do_pop};
    end
  end
endmodule

// file: eqes_top.sv
// Error classification, error queue and standard event flags with summary bit
// Notes on behaviour
// RULE1: Bad text, wrong or unknown compound, wrong parameter log command errors.
// RULE2: Parser overflow logs a command-category error 190.
// RULE3: Out-of-range numeric setting is refused and logs execution error 200.
// RULE4: Hardware, software, disabled feature and key emulation faults log device errors.
// RULE5: Queue holds thirty-two entries; overflow records too-many-errors 400.
// RULE6: A query while a response is unread logs query error 410.
// RULE7: A read with no response data logs query error 420.
// RULE8: More than 250 received characters log device error 500.
// RULE9: Laser enable with interlock open is refused with an execution error.
// RULE10: Laser enable with open circuit is refused with error 1002.
// RULE11: Laser enable at over-temperature is refused with error 1003.
// RULE12: Polarity changes while laser on are refused with 1005, 1006, 1013.
// RULE13: Current setpoint in constant power, monitor setpoint in constant current refused.
// RULE14: Laser enable outside temperature window is refused with error 1010.
// RULE15: Bias switching while laser on is refused with error 1012.
// RULE16: Calibration while laser on is refused with error 1014.
// RULE17: Mode change while laser on is refused with error 1016.
// RULE18: Range change refused while laser on (1017) or bias on (1018).
// RULE19: Eight-bit event flags and enable mask registers are provided here.
// RULE20: Flags hold power-on, command, execution, device, query, operation complete.
// RULE21: Reading the flags returns them and clears them; no direct write.
// RULE22: OR of flags ANDed with mask drives the event summary bit.
// RULE23: Each queue query removes and returns the oldest entry.
// RULE24: Querying an empty queue returns code zero.
// RULE25: Each queued error sets the flag of its category.
// RULE26: A refused request changes nothing but the error log and flag.
`timescale 1ns/1ps
module eqes_top (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        err_bad_text,
  input  wire logic                        err_wrong_compound,
  input  wire logic                        err_unknown_compound,
  input  wire logic                        err_wrong_param,
  input  wire logic                        err_parser_overflow,
  input  wire logic                        err_hw_fault,
  input  wire logic                        err_sw_fault,
  input  wire logic                        err_not_enabled,
  input  wire logic                        err_key_emul,
  input  wire logic                        rx_char,
  input  wire logic                        rx_end,
  input  wire logic                        query_in,
  input  wire logic                        out_read,
  input  wire logic                        opc_cmd,
  input  wire logic                        req_valid,
  input  wire eqes_pkg::eqes_req_e         req_kind,
  input  wire logic                        req_out_of_range,
  input  wire logic                        laser_on,
  input  wire logic                        const_power_mode,
  input  wire logic                        bias_on,
  input  wire logic                        interlock_open,
  input  wire logic                        open_circuit,
  input  wire logic                        over_temp,
  input  wire logic                        temp_window_fault,
  input  wire logic                        flags_rd,
  input  wire logic                        mask_rd,
  input  wire logic                        mask_wr,
  input  wire logic [7:0]                  mask_wdata,
  input  wire logic                        errq_rd,
  output logic                             req_grant,
  output logic                             req_refuse,
  output logic                             resp_valid,
  output logic      [eqes_pkg::CODE_W-1:0] resp_data,
  output logic                             event_summary_bit,
  output logic                             error_available,
  output logic      [5:0]                  errq_count
);
  import eqes_pkg::*;

  logic [3:0]        pin_meta_r;
  logic [3:0]        pin_sync_r;
  logic              ilk_s;
  logic              open_s;
  logic              temp_s;
  logic              win_s;
  logic [15:0]       refuse_code;
  logic [15:0]       err_code;
  logic              cmd_any;
  logic              exe_any;
  logic              dev_any;
  logic              qry_any;
  logic              rx_ovf_hit;
  logic              qry_intr;
  logic              qry_unterm;
  logic              q_push;
  logic [15:0]       q_push_data;
  logic              q_pop;
  logic [15:0]       q_head;
  logic [5:0]        q_count;
  logic              q_overflow;
  logic [7:0]        ev_set;
  logic [7:0]        flags_r;
  logic [7:0]        flags_nxt;
  logic [7:0]        mask_r;
  logic [7:0]        rx_cnt_r;
  logic              rx_ovf_r;
  logic              pending_r;
  logic              grant_r;
  logic              refuse_r;
  logic              resp_valid_r;
  logic [15:0]       resp_data_r;
  logic              summary_r;

  // Fault pins come from the analog side and are synchronised first
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {temp_window_fault, over_temp, open_circuit, interlock_open};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign ilk_s  = pin_sync_r[0];
  assign open_s = pin_sync_r[1];
  assign temp_s = pin_sync_r[2];
  assign win_s  = pin_sync_r[3];

  // Request screening; a non-zero code means refused
  always_comb begin
    refuse_code = ERR_NONE;
    if (req_valid) begin
      if (req_out_of_range) begin
        refuse_code = ERR_RANGE; // see RULE3
      end else begin
        unique case (req_kind)
          REQ_LASER_ON: begin
            if (ilk_s) begin
              refuse_code = ERR_INTERLOCK; // see RULE9
            end else if (open_s) begin
              refuse_code = ERR_OPEN_CIRC; // see RULE10
            end else if (temp_s) begin
              refuse_code = ERR_OVER_TEMP; // see RULE11
            end else if (win_s) begin
              refuse_code = ERR_TEMP_WIN; // see RULE14
            end
          end
          REQ_LASER_POL: begin
            if (laser_on) begin
              refuse_code = ERR_LASER_POL; // see RULE12
            end
          end
          REQ_MON_POL: begin
            if (laser_on) begin
              refuse_code = ERR_MON_POL; // see RULE12
            end
          end
          REQ_MON_POL_SETUP: begin
            if (laser_on) begin
              refuse_code = ERR_MON_POL_SET; // see RULE12
            end
          end
          REQ_LASER_CURRENT: begin
            if (const_power_mode) begin
              refuse_code = ERR_CUR_IN_CP; // see RULE13
            end
          end
          REQ_MONITOR_SETPOINT: begin
            if (!const_power_mode) begin
              refuse_code = ERR_MON_IN_CC; // see RULE13
            end
          end
          REQ_BIAS_SWITCH: begin
            if (laser_on) begin
              refuse_code = ERR_BIAS_SW; // see RULE15
            end
          end
          REQ_CALIBRATE: begin
            if (laser_on) begin
              refuse_code = ERR_CALIBRATE; // see RULE16
            end
          end
          REQ_MODE: begin
            if (laser_on) begin
              refuse_code = ERR_MODE; // see RULE17
            end
          end
          REQ_MON_RANGE: begin
            if (laser_on) begin
              refuse_code = ERR_RANGE_LASER; // see RULE18
            end else if (bias_on) begin
              refuse_code = ERR_RANGE_BIAS; // see RULE18
            end
          end
          default: refuse_code = ERR_NONE;
        endcase
      end
    end
  end

  // Setting logic applies a request only on grant
  always_ff @(posedge clk) begin
    if (srst) begin
      grant_r  <= 1'b0;
      refuse_r <= 1'b0;
    end else begin
      grant_r  <= req_valid && (refuse_code == ERR_NONE); // see RULE26
      refuse_r <= req_valid && (refuse_code != ERR_NONE);
    end
  end

  // Receive length and response bookkeeping
  assign rx_ovf_hit = rx_char && !rx_end && (rx_cnt_r == RX_MAX) && !rx_ovf_r; // see RULE8
  assign qry_intr   = query_in && pending_r; // see RULE6
  assign qry_unterm = out_read && !pending_r; // see RULE7

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_cnt_r <= 8'h00;
      rx_ovf_r <= 1'b0;
    end else if (rx_end) begin
      rx_cnt_r <= 8'h00;
      rx_ovf_r <= 1'b0;
    end else if (rx_char) begin
      if (rx_cnt_r != RX_MAX) begin
        rx_cnt_r <= rx_cnt_r + 8'h01;
      end else begin
        rx_ovf_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pending_r <= 1'b0;
    end else if (query_in) begin
      pending_r <= 1'b1;
    end else if (out_read) begin
      pending_r <= 1'b0;
    end
  end

  // One code per cycle is queued, in order: command errors, refused request, device faults, query errors, receive overflow
  always_comb begin
    err_code = ERR_NONE;
    if (err_bad_text) begin
      err_code = ERR_BAD_TEXT; // see RULE1
    end else if (err_wrong_compound) begin
      err_code = ERR_WRONG_COMP; // see RULE1
    end else if (err_unknown_compound) begin
      err_code = ERR_UNKNOWN_COMP; // see RULE1
    end else if (err_wrong_param) begin
      err_code = ERR_WRONG_PARAM; // see RULE1
    end else if (err_parser_overflow) begin
      err_code = ERR_PARSER_OVF; // see RULE2
    end else if (refuse_code != ERR_NONE) begin
      err_code = refuse_code;
    end else if (err_hw_fault) begin
      err_code = ERR_HW; // see RULE4
    end else if (err_sw_fault) begin
      err_code = ERR_SW; // see RULE4
    end else if (err_not_enabled) begin
      err_code = ERR_NOT_ENABLED; // see RULE4
    end else if (err_key_emul) begin
      err_code = ERR_KEY_EMUL; // see RULE4
    end else if (qry_intr) begin
      err_code = ERR_QRY_INTR;
    end else if (qry_unterm) begin
      err_code = ERR_QRY_UNTERM;
    end else if (rx_ovf_hit) begin
      err_code = ERR_RX_OVF;
    end
  end

  // Last free slot takes the overflow marker, later errors are dropped
  assign q_overflow  = (err_code != ERR_NONE) && (q_count == QLAST_CNT);
  assign q_push      = (err_code != ERR_NONE) && (q_count != QFULL_CNT);
  assign q_push_data = q_overflow ? ERR_TOO_MANY : err_code; // see RULE5
  assign q_pop       = errq_rd; // see RULE23

  eqes_errq u_errq (
    .clk       (clk),
    .srst      (srst),
    .push      (q_push),
    .push_data (q_push_data),
    .pop       (q_pop),
    .head      (q_head),
    .count     (q_count)
  );

  // Category flags follow every source, even one not queued this cycle
  assign cmd_any = err_bad_text || err_wrong_compound || err_unknown_compound ||
                   err_wrong_param || err_parser_overflow;
  assign exe_any = refuse_code != ERR_NONE;
  assign dev_any = err_hw_fault || err_sw_fault || err_not_enabled || err_key_emul ||
                   rx_ovf_hit || q_overflow;
  assign qry_any = qry_intr || qry_unterm;

  always_comb begin
    ev_set         = 8'h00;
    ev_set[EV_OPC] = opc_cmd; // see RULE20
    ev_set[EV_QYE] = qry_any; // see RULE25
    ev_set[EV_DDE] = dev_any; // see RULE25
    ev_set[EV_EXE] = exe_any; // see RULE25
    ev_set[EV_CME] = cmd_any; // see RULE25
  end

  // Read clears, new events in the same cycle survive the clear
  assign flags_nxt = (flags_rd ? 8'h00 : flags_r) | ev_set; // see RULE21

  always_ff @(posedge clk) begin
    if (srst) begin
      flags_r <= FLAGS_RST; // see RULE19
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_r <= MASK_RST;
    end else if (mask_wr) begin
      mask_r <= mask_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      summary_r <= 1'b0;
    end else begin
      summary_r <= |(flags_r & mask_r); // see RULE22
    end
  end

  // Answers: queue query first, then flags, then mask
  always_ff @(posedge clk) begin
    if (srst) begin
      resp_valid_r <= 1'b0;
      resp_data_r  <= 16'h0000;
    end else begin
      resp_valid_r <= errq_rd || flags_rd || mask_rd;
      if (errq_rd) begin
        resp_data_r <= (q_count == 6'h00) ? ERR_NONE : q_head; // see RULE24
      end else if (flags_rd) begin
        resp_data_r <= {8'h00, flags_r};
      end else if (mask_rd) begin
        resp_data_r <= {8'h00, mask_r};
      end
    end
  end

  assign req_grant         = grant_r;
  assign req_refuse        = refuse_r;
  assign resp_valid        = resp_valid_r;
  assign resp_data         = resp_data_r;
  assign event_summary_bit = summary_r;
  assign error_available   = q_count != 6'h00;
  assign errq_count        = q_count;

  property p_q_bound;
    @(posedge clk) disable iff (srst) q_count <= QFULL_CNT;
  endproperty
  a_q_bound: assert property (p_q_bound) else $error("queue count above depth"); // see RULE5

  property p_q_overflow;
    @(posedge clk) disable iff (srst) q_overflow && !errq_rd |=> q_count == QFULL_CNT;
  endproperty
  a_q_overflow: assert property (p_q_overflow) else $error("overflow marker not stored"); // see RULE5

  property p_empty_zero;
    @(posedge clk) disable iff (srst) errq_rd && q_count == 6'h00 |=> resp_valid && resp_data == 16'h0000;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty queue query not zero"); // see RULE24

  property p_pop_one;
    @(posedge clk) disable iff (srst) errq_rd && q_count != 6'h00 && !q_push |=> q_count == $past(q_count) - 6'h01;
  endproperty
  a_pop_one: assert property (p_pop_one) else $error("queue query did not remove one entry"); // see RULE23

  property p_flags_clear;
    @(posedge clk) disable iff (srst) flags_rd && !errq_rd && ev_set == 8'h00 |=>
      flags_r == 8'h00 && resp_data[7:0] == $past(flags_r);
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flag read did not return and clear"); // see RULE21

  property p_summary;
    @(posedge clk) disable iff (srst) (flags_r & mask_r) != 8'h00 [*2] |-> event_summary_bit;
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit missing"); // see RULE22

  property p_interlock;
    @(posedge clk) disable iff (srst) req_valid && req_kind == REQ_LASER_ON && ilk_s |=>
      req_refuse && !req_grant && flags_r[EV_EXE];
  endproperty
  a_interlock: assert property (p_interlock) else $error("enable granted with interlock open"); // see RULE9

  property p_polarity;
    @(posedge clk) disable iff (srst) req_valid && req_kind == REQ_LASER_POL && laser_on |=> req_refuse;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity change granted while on"); // see RULE12

  property p_mode_cp;
    @(posedge clk) disable iff (srst) req_valid && req_kind == REQ_LASER_CURRENT && const_power_mode |=> !req_grant;
  endproperty
  a_mode_cp: assert property (p_mode_cp) else $error("current setpoint granted in power mode"); // see RULE13

  property p_range_bias;
    @(posedge clk) disable iff (srst) req_valid && req_kind == REQ_MON_RANGE && bias_on && !req_out_of_range |=>
      req_refuse;
  endproperty
  a_range_bias: assert property (p_range_bias) else $error("range change granted with bias on"); // see RULE18

  property p_query_intr;
    @(posedge clk) disable iff (srst) query_in && pending_r |=> flags_r[EV_QYE];
  endproperty
  a_query_intr: assert property (p_query_intr) else $error("interrupted query not flagged"); // see RULE6

  property p_cmd_flag;
    @(posedge clk) disable iff (srst) err_bad_text |=> flags_r[EV_CME];
  endproperty
  a_cmd_flag: assert property (p_cmd_flag) else $error("command error not flagged"); // see RULE1
endmodule

// file: eqes_host.sv
// Host model that turns bench commands into register read and mask write pulses
`timescale 1ns/1ps
module eqes_host (
  input  wire logic       clk,
  input  wire logic [2:0] cmd,
  input  wire logic [7:0] wdata,
  output logic            flags_rd,
  output logic            mask_rd,
  output logic            errq_rd,
  output logic            mask_wr,
  output logic      [7:0] mask_wdata
);
  // Each command becomes one single-cycle pulse; write data travels with it
  always_ff @(posedge clk) begin
    flags_rd   <= (cmd == 3'h1);
    mask_rd    <= (cmd == 3'h2);
    errq_rd    <= (cmd == 3'h3);
    mask_wr    <= (cmd == 3'h4);
    mask_wdata <= (cmd == 3'h4) ? wdata : ~mask_wdata;
  end
endmodule

// file: eqes_top_bench.sv
// Self-checking bench for the error queue and event status logic
`timescale 1ns/1ps
module eqes_top_bench;
  import eqes_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [13:0] pv = '0;
  logic [3:0]  pins = '0;
  logic [2:0]  cmd = '0;
  logic [7:0]  wdata = '0;
  logic        req_valid = 1'b0, req_out_of_range = 1'b0, laser_on = 1'b0, const_power_mode = 1'b0, bias_on = 1'b0;
  eqes_req_e   req_kind = REQ_LASER_ON;
  logic        flags_rd, mask_rd, errq_rd, mask_wr, req_grant, req_refuse, resp_valid, event_summary_bit;
  logic        error_available;
  logic [7:0]  mask_wdata, m;
  logic [15:0] resp_data, got;
  logic [5:0]  errq_count;
  logic [15:0] pcode [9] = '{ERR_BAD_TEXT, ERR_WRONG_COMP, ERR_UNKNOWN_COMP, ERR_WRONG_PARAM, ERR_PARSER_OVF,
                             ERR_HW, ERR_SW, ERR_NOT_ENABLED, ERR_KEY_EMUL};
  logic [15:0] pin_code [4] = '{ERR_INTERLOCK, ERR_OPEN_CIRC, ERR_OVER_TEMP, ERR_TEMP_WIN};
  logic [15:0] q [$];
  int          n_errors = 0;
  int          comparisons = 0;
  int          k;

  always #10 clk = ~clk;

  eqes_host host_i (.clk, .cmd, .wdata, .flags_rd, .mask_rd, .errq_rd, .mask_wr, .mask_wdata);
  eqes_top uut (.clk, .srst, .err_bad_text(pv[0]), .err_wrong_compound(pv[1]), .err_unknown_compound(pv[2]),
    .err_wrong_param(pv[3]), .err_parser_overflow(pv[4]), .err_hw_fault(pv[5]), .err_sw_fault(pv[6]),
    .err_not_enabled(pv[7]), .err_key_emul(pv[8]), .rx_char(pv[9]), .rx_end(pv[10]), .query_in(pv[11]),
    .out_read(pv[12]), .opc_cmd(pv[13]), .req_valid, .req_kind, .req_out_of_range, .laser_on, .const_power_mode,
    .bias_on, .interlock_open(pins[0]), .open_circuit(pins[1]), .over_temp(pins[2]), .temp_window_fault(pins[3]),
    .flags_rd, .mask_rd, .mask_wr, .mask_wdata, .errq_rd, .req_grant, .req_refuse, .resp_valid, .resp_data,
    .event_summary_bit, .error_available, .errq_count);

  function automatic int cat_bit(logic [15:0] code);
    if (code < 16'h00c8) return EV_CME;
    if (code < 16'h012c || code > 16'h03e7) return EV_EXE;
    if (code == ERR_QRY_INTR || code == ERR_QRY_UNTERM) return EV_QYE;
    return EV_DDE;
  endfunction

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic host(logic [2:0] c, logic [7:0] d = 8'h00);
    @(posedge clk);
    cmd <= c;
    wdata <= d;
    @(posedge clk);
    cmd <= 3'h0;
    @(posedge clk);
    #1;
    got = resp_data;
    if (c != 3'h4) check("resp_valid", {15'h0, resp_valid}, 16'h0001);
  endtask

  task automatic pulse(int b);
    @(posedge clk);
    pv[b] <= 1'b1;
    @(posedge clk);
    pv <= '0;
  endtask

  // Pops one entry and checks it and the category flag it raised
  task automatic expect_err(logic [15:0] code);
    host(3'h3);
    check("queue head", got, code);
    host(3'h1);
    check("event flags", got, 16'h0001 << cat_bit(code));
  endtask

  task automatic request(eqes_req_e kd, logic oor, logic lo, logic cpm, logic bi, logic [15:0] code);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= kd;
    req_out_of_range <= oor;
    laser_on <= lo;
    const_power_mode <= cpm;
    bias_on <= bi;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    check("grant refuse", {14'h0, req_grant, req_refuse}, (code == 16'h0) ? 16'h2 : 16'h1);
    if (code != 16'h0) expect_err(code);
    else check("queue count", {10'h0, errq_count}, 16'h0);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(83));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    host(3'h1);
    check("flags after reset", got, 16'h0080);
    host(3'h1);
    check("flags after read", got, 16'h0000);
    host(3'h2);
    check("mask after reset", got, 16'h0000);
    host(3'h3);
    check("empty queue", got, ERR_NONE);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      pulse(i);
      expect_err(pcode[i]);
    end
    $display("test error sources done");
    request(REQ_MODE, 1'b1, 1'b0, 1'b0, 1'b0, ERR_RANGE);
    request(REQ_LASER_POL, 1'b0, 1'b1, 1'b0, 1'b0, ERR_LASER_POL);
    request(REQ_MON_POL, 1'b0, 1'b1, 1'b0, 1'b0, ERR_MON_POL);
    request(REQ_MON_POL_SETUP, 1'b0, 1'b1, 1'b0, 1'b0, ERR_MON_POL_SET);
    request(REQ_LASER_CURRENT, 1'b0, 1'b0, 1'b1, 1'b0, ERR_CUR_IN_CP);
    request(REQ_MONITOR_SETPOINT, 1'b0, 1'b0, 1'b0, 1'b0, ERR_MON_IN_CC);
    request(REQ_BIAS_SWITCH, 1'b0, 1'b1, 1'b0, 1'b0, ERR_BIAS_SW);
    request(REQ_CALIBRATE, 1'b0, 1'b1, 1'b0, 1'b0, ERR_CALIBRATE);
    request(REQ_MODE, 1'b0, 1'b1, 1'b0, 1'b0, ERR_MODE);
    request(REQ_MON_RANGE, 1'b0, 1'b1, 1'b0, 1'b1, ERR_RANGE_LASER);
    request(REQ_MON_RANGE, 1'b0, 1'b0, 1'b0, 1'b1, ERR_RANGE_BIAS);
    request(REQ_MODE, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pins <= 4'h1 << i;
      repeat (4) @(posedge clk);
      request(REQ_LASER_ON, 1'b0, 1'b0, 1'b0, 1'b0, pin_code[i]);
    end
    @(posedge clk);
    pins <= 4'h0;
    repeat (4) @(posedge clk);
    request(REQ_LASER_ON, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0);
    $display("test requests done");
    pulse(11);
    pulse(11);
    expect_err(ERR_QRY_INTR);
    pulse(12);
    pulse(12);
    expect_err(ERR_QRY_UNTERM);
    $display("test query done");
    repeat (250) pulse(9);
    #1;
    check("count at 250 chars", {10'h0, errq_count}, 16'h0);
    pulse(9);
    pulse(10);
    expect_err(ERR_RX_OVF);
    $display("test receive done");
    for (int i = 0; i < 33; i++) begin
      k = $urandom_range(8);
      pulse(k);
      q.push_back((i == 31) ? ERR_TOO_MANY : pcode[k]);
    end
    #1;
    check("queue full", {10'h0, errq_count}, 16'h0020);
    check("error available while full", {15'h0, error_available}, 16'h0001);
    for (int i = 0; i < 32; i++) begin
      host(3'h3);
      check("queue order", got, q[i]);
    end
    check("error available", {15'h0, error_available}, 16'h0);
    $display("test overflow done");
    host(3'h1);
    for (int i = 0; i < 6; i++) begin
      m = 8'($urandom);
      k = $urandom_range(9);
      host(3'h4, m);
      host(3'h2);
      check("mask readback", got, {8'h00, m});
      pulse((k == 9) ? 13 : k);
      k = (k == 9) ? EV_OPC : cat_bit(pcode[k]);
      repeat (2) @(posedge clk);
      #1;
      check("summary", {15'h0, event_summary_bit}, {15'h0, |(m & (8'h01 << k))});
      host(3'h1);
      repeat (2) @(posedge clk);
      #1;
      check("summary after clear", {15'h0, event_summary_bit}, 16'h0);
    end
    $display("test summary done");
    give_verdict();
  end
endmodule
